/* hw/lar_elem_if.sv */
`timescale 1ns/1ps
// one element's feedback selection bundle
interface lar_elem_if;
   logic [10:0] ctrl;
   logic sw_bit;
   logic [15:0] outs;
   logic elem_in;
   logic fb1;
   modport mux (input ctrl, input sw_bit, input outs, output elem_in, output fb1);
   modport top (output ctrl, output sw_bit, output outs, input elem_in, input fb1);
endinterface : lar_elem_if

/* hw/lar_fb_mux.sv */
`timescale 1ns/1ps
`include "lar_params.svh"
// feedback multiplexers of one element
module lar_fb_mux #(
   parameter int IDX = 0
) (
   lar_elem_if.mux eif
);
   // block base: elements 0..7 or 8..15
   localparam lar_pkg::lar_idx_t BASE = (IDX >= 8) ? 4'h8 : 4'h0;
   localparam lar_pkg::lar_idx_t SELF = 4'(IDX);

   logic [1:0] fb0_code;
   logic [1:0] fb1_code;
   lar_pkg::lar_idx_t fb0_idx;
   lar_pkg::lar_idx_t fb1_idx;

   assign fb0_code = eif.ctrl[`LAR_FB0_LO +: 2];
   assign fb1_code = eif.ctrl[`LAR_FB1_LO +: 2];

   // index pick; first mux code 0 of a block's first element wraps to the element before it
   always_comb begin
      // R3: first mux map
      fb0_idx = BASE + {1'b0, fb0_code, 1'b0};
      if (fb0_code == 2'h0 && SELF == BASE) begin
         fb0_idx = BASE - 4'h1;
      end
      // R4: second mux map
      fb1_idx = BASE + {1'b0, fb1_code, 1'b1};
   end

   // R11: input select
   assign eif.elem_in = eif.ctrl[`LAR_IN_SEL_BIT] ? eif.outs[fb0_idx] : eif.sw_bit;
   assign eif.fb1 = eif.outs[fb1_idx];
endmodule : lar_fb_mux

/* hw/lar_params.svh */
// Functional notes
// R1: irq 1 enable bit 12, source [11:8]
// R2: irq 0 enable bit 4, source [3:0]
// R3: first feedback mux [10:9] element map
// R4: second feedback mux [8:7] element map
// R5: converter trigger enable bit 4, source [3:0]
// R6: software input register bits [15:0] writable
// R7: element outputs readable, always up to date
// R8: lock bit 0 written once after reset
// R9: lock blocks config writes, software inputs stay open
// R10: irq 0 at source bit 21, 1 at 24
// R11: input select bit 6 picks feedback or software
// R12: enabled outputs follow element, disabled held low
`ifndef LAR_PARAMS_SVH
`define LAR_PARAMS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define LAR_ADDR_IRQ_ROUTE 32'hFFFF0B44
`define LAR_ADDR_CONV_TRIG 32'hFFFF0B48
`define LAR_ADDR_SW_INPUTS 32'hFFFF0B4C
`define LAR_ADDR_ELEM_OUTS 32'hFFFF0B50
`define LAR_ADDR_CFG_LOCK 32'hFFFF0B54
`define LAR_ADDR_EVT_STATUS 32'hFFFF0B58
`define LAR_ADDR_EVT_MASK 32'hFFFF0B5C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LAR_IRQ1_EN_BIT 12
`define LAR_IRQ1_SRC_LO 8
`define LAR_IRQ0_EN_BIT 4
`define LAR_IRQ0_SRC_LO 0
`define LAR_TRIG_EN_BIT 4
`define LAR_TRIG_SRC_LO 0
`define LAR_LOCK_BIT 0
`define LAR_FB0_LO 9
`define LAR_FB1_LO 7
`define LAR_IN_SEL_BIT 6
`define LAR_ELEM_CTRL_W 11
`define LAR_INTC_IRQ0_BIT 21
`define LAR_INTC_IRQ1_BIT 24
`define LAR_EVT_IRQ0 0
`define LAR_EVT_IRQ1 1
`define LAR_EVT_TRIG 2
`define LAR_EVT_LOCKED_WR 3
`define LAR_EVT_W 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LAR_RST_SW_INPUTS 16'h0000
`define LAR_RST_EVT 4'h0

`endif

/* hw/lar_pkg.sv */
package lar_pkg;
   // element index, 0 to 15
   typedef logic [3:0] lar_idx_t;
   // interrupt routing fields, reserved bits not stored
   typedef struct packed {
      logic irq1_en;
      lar_idx_t irq1_src;
      logic irq0_en;
      lar_idx_t irq0_src;
   } lar_route_t;
   // converter trigger fields
   typedef struct packed {
      logic en;
      lar_idx_t src;
   } lar_trig_t;
endpackage : lar_pkg

/* hw/lar_routing_lock.sv */
`timescale 1ns/1ps
`include "lar_params.svh"
// routing, feedback, software data and lock tail of the logic array
module lar_routing_lock #(
   parameter int N_ELEM = 16
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [N_ELEM-1:0] ELEM_OUT,
   input wire logic [N_ELEM*11-1:0] ELEM_CTRL,
   output logic [N_ELEM-1:0] ELEM_IN,
   output logic [N_ELEM-1:0] ELEM_FB1,
   output logic ARRAY_IRQ0,
   output logic ARRAY_IRQ1,
   output logic ADC_TRIG,
   output logic [31:0] INTC_SRC,
   output logic CFG_LOCKED,
   output logic EVT_IRQ
);
   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic setup_rd;
   logic acc_wr;
   logic addr_ok;

   // zero wait state slave: every access phase completes at once
   assign setup_rd = PSEL && !PENABLE && !PWRITE;
   assign acc_wr = PSEL && PENABLE && PWRITE;
   assign PREADY = PSEL && PENABLE;

   // mapped address check
   always_comb begin
      unique case (PADDR)
         `LAR_ADDR_IRQ_ROUTE, `LAR_ADDR_CONV_TRIG, `LAR_ADDR_SW_INPUTS,
         `LAR_ADDR_ELEM_OUTS, `LAR_ADDR_CFG_LOCK, `LAR_ADDR_EVT_STATUS,
         `LAR_ADDR_EVT_MASK: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   assign PSLVERR = PSEL && PENABLE && !addr_ok;

   // ----------------------------------------------------------------
   // configuration registers and lock
   // ----------------------------------------------------------------
   lar_pkg::lar_route_t route_q;
   lar_pkg::lar_route_t route_d;
   lar_pkg::lar_trig_t trig_q;
   lar_pkg::lar_trig_t trig_d;
   logic [15:0] sw_in_q;
   logic [15:0] sw_in_d;
   logic lock_q;
   logic lock_d;
   logic lock_used_q;
   logic lock_used_d;
   logic locked_wr;

   // next values of the configuration
   always_comb begin
      route_d = route_q;
      trig_d = trig_q;
      sw_in_d = sw_in_q;
      lock_d = lock_q;
      lock_used_d = lock_used_q;
      locked_wr = 1'b0;
      if (acc_wr) begin
         unique case (PADDR)
            `LAR_ADDR_IRQ_ROUTE: begin
               // R9: routing frozen
               if (lock_q) begin
                  locked_wr = 1'b1;
               end else begin
                  // R1: irq 1 fields
                  route_d.irq1_en = PWDATA[`LAR_IRQ1_EN_BIT];
                  route_d.irq1_src = PWDATA[`LAR_IRQ1_SRC_LO +: 4];
                  // R2: irq 0 fields
                  route_d.irq0_en = PWDATA[`LAR_IRQ0_EN_BIT];
                  route_d.irq0_src = PWDATA[`LAR_IRQ0_SRC_LO +: 4];
               end
            end
            `LAR_ADDR_CONV_TRIG: begin
               // R9: trigger frozen
               if (lock_q) begin
                  locked_wr = 1'b1;
               end else begin
                  // R5: trigger fields
                  trig_d.en = PWDATA[`LAR_TRIG_EN_BIT];
                  trig_d.src = PWDATA[`LAR_TRIG_SRC_LO +: 4];
               end
            end
            // R6: software inputs, never locked
            `LAR_ADDR_SW_INPUTS: sw_in_d = PWDATA[15:0];
            `LAR_ADDR_CFG_LOCK: begin
               // R8: first write only
               if (lock_used_q) begin
                  locked_wr = 1'b1;
               end else begin
                  lock_d = PWDATA[`LAR_LOCK_BIT];
                  lock_used_d = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // configuration flops
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         route_q <= '0;
         trig_q <= '0;
         sw_in_q <= `LAR_RST_SW_INPUTS;
         lock_q <= 1'b0;
         lock_used_q <= 1'b0;
      end else begin
         route_q <= route_d;
         trig_q <= trig_d;
         sw_in_q <= sw_in_d;
         lock_q <= lock_d;
         lock_used_q <= lock_used_d;
      end
   end

   assign CFG_LOCKED = lock_q;

   // ----------------------------------------------------------------
   // feedback multiplexers, one per element
   // ----------------------------------------------------------------
   logic [N_ELEM-1:0] elem_in_c;

   for (genvar g = 0; g < N_ELEM; g++) begin : g_elem
      lar_elem_if eif ();
      assign eif.ctrl = ELEM_CTRL[g*`LAR_ELEM_CTRL_W +: `LAR_ELEM_CTRL_W];
      assign eif.sw_bit = sw_in_q[g];
      assign eif.outs = ELEM_OUT;
      assign elem_in_c[g] = eif.elem_in;
      assign ELEM_FB1[g] = eif.fb1;
      lar_fb_mux #(.IDX(g)) u_mux (
         .eif(eif.mux)
      );
   end

   // ----------------------------------------------------------------
   // routed outputs, events and read data
   // ----------------------------------------------------------------
   logic irq0_q;
   logic irq0_d;
   logic irq1_q;
   logic irq1_d;
   logic trig_out_q;
   logic trig_out_d;
   logic [N_ELEM-1:0] elem_in_q;
   logic [`LAR_EVT_W-1:0] evt_q;
   logic [`LAR_EVT_W-1:0] evt_d;
   logic [`LAR_EVT_W-1:0] evt_set;
   logic [`LAR_EVT_W-1:0] mask_q;
   logic [`LAR_EVT_W-1:0] mask_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;

   // one register stage on each routed output; a disabled one sits low
   always_comb begin
      // R12: gated follow
      irq0_d = route_q.irq0_en && ELEM_OUT[route_q.irq0_src];
      irq1_d = route_q.irq1_en && ELEM_OUT[route_q.irq1_src];
      // R5: gated trigger
      trig_out_d = trig_q.en && ELEM_OUT[trig_q.src];
   end

   // events: rising edges of routed outputs and refused writes
   always_comb begin
      evt_set = '0;
      evt_set[`LAR_EVT_IRQ0] = irq0_d && !irq0_q;
      evt_set[`LAR_EVT_IRQ1] = irq1_d && !irq1_q;
      evt_set[`LAR_EVT_TRIG] = trig_out_d && !trig_out_q;
      evt_set[`LAR_EVT_LOCKED_WR] = locked_wr;
      mask_d = mask_q;
      evt_d = evt_q;
      if (acc_wr && PADDR == `LAR_ADDR_EVT_STATUS) begin
         evt_d = evt_q & ~PWDATA[`LAR_EVT_W-1:0];
      end
      if (acc_wr && PADDR == `LAR_ADDR_EVT_MASK) begin
         mask_d = PWDATA[`LAR_EVT_W-1:0];
      end
      // a new event beats a clear in the same cycle
      evt_d = evt_d | evt_set;
   end

   // read data latched in the setup cycle, shown through the access phase
   always_comb begin
      prdata_d = prdata_q;
      if (setup_rd) begin
         prdata_d = 32'h0000_0000;
         unique case (PADDR)
            `LAR_ADDR_IRQ_ROUTE: begin
               prdata_d[`LAR_IRQ1_EN_BIT] = route_q.irq1_en;
               prdata_d[`LAR_IRQ1_SRC_LO +: 4] = route_q.irq1_src;
               prdata_d[`LAR_IRQ0_EN_BIT] = route_q.irq0_en;
               prdata_d[`LAR_IRQ0_SRC_LO +: 4] = route_q.irq0_src;
            end
            `LAR_ADDR_CONV_TRIG: begin
               prdata_d[`LAR_TRIG_EN_BIT] = trig_q.en;
               prdata_d[`LAR_TRIG_SRC_LO +: 4] = trig_q.src;
            end
            `LAR_ADDR_SW_INPUTS: prdata_d[15:0] = sw_in_q;
            // R7: live element outputs
            `LAR_ADDR_ELEM_OUTS: prdata_d[N_ELEM-1:0] = ELEM_OUT;
            `LAR_ADDR_EVT_STATUS: prdata_d[`LAR_EVT_W-1:0] = evt_q;
            `LAR_ADDR_EVT_MASK: prdata_d[`LAR_EVT_W-1:0] = mask_q;
            // lock register is write only and reads zero
            default: begin
            end
         endcase
      end
   end

   // output, event and read flops
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         irq0_q <= 1'b0;
         irq1_q <= 1'b0;
         trig_out_q <= 1'b0;
         elem_in_q <= '0;
         evt_q <= `LAR_RST_EVT;
         mask_q <= `LAR_RST_EVT;
         prdata_q <= 32'h0000_0000;
      end else begin
         irq0_q <= irq0_d;
         irq1_q <= irq1_d;
         trig_out_q <= trig_out_d;
         elem_in_q <= elem_in_c;
         evt_q <= evt_d;
         mask_q <= mask_d;
         prdata_q <= prdata_d;
      end
   end

   assign ARRAY_IRQ0 = irq0_q;
   assign ARRAY_IRQ1 = irq1_q;
   assign ADC_TRIG = trig_out_q;
   assign ELEM_IN = elem_in_q;
   assign PRDATA = prdata_q;
   assign EVT_IRQ = |(evt_q & mask_q);

   // source bits as the interrupt controller sees them
   always_comb begin
      INTC_SRC = 32'h0000_0000;
      // R10: source bit map
      INTC_SRC[`LAR_INTC_IRQ0_BIT] = irq0_q;
      INTC_SRC[`LAR_INTC_IRQ1_BIT] = irq1_q;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SYS_RST);

   AST_IRQ1_FOLLOW: assert property (route_q.irq1_en && ELEM_OUT[route_q.irq1_src] |=> ARRAY_IRQ1) // R1
      else $error("irq 1 did not follow its source element");
   AST_IRQ0_OFF: assert property (!route_q.irq0_en |=> !ARRAY_IRQ0 && !INTC_SRC[21]) // R2
      else $error("disabled irq 0 went high");
   AST_ELEM0_WRAP: assert property (ELEM_CTRL[6] && ELEM_CTRL[10:9] == 2'h0 |=> ELEM_IN[0] == $past(ELEM_OUT[15])) // R3
      else $error("element 0 feedback code 0 did not pick element 15");
   AST_ELEM9_FB1: assert property (ELEM_CTRL[9*11+7 +: 2] == 2'h3 |-> ELEM_FB1[9] == ELEM_OUT[15]) // R4
      else $error("element 9 second mux code 3 did not pick element 15");
   AST_TRIG_BLOCK: assert property (!trig_q.en [*2] |-> !ADC_TRIG) // R5
      else $error("blocked trigger went high");
   AST_SWIN_OPEN: assert property (acc_wr && PADDR == 32'hFFFF0B4C |=> sw_in_q == $past(PWDATA[15:0])) // R6
      else $error("software input write lost");
   AST_DOUT_READ: assert property (setup_rd && PADDR == 32'hFFFF0B50 |=> PRDATA == {16'h0000, $past(ELEM_OUT)}) // R7
      else $error("output word read wrong");
   AST_LOCK_ONCE: assert property (lock_used_q |=> $stable(lock_q)) // R8
      else $error("lock bit changed after its one write");
   AST_ROUTE_FROZEN: assert property (lock_q && acc_wr |=> $stable(route_q) && $stable(trig_q)) // R9
      else $error("configuration changed while locked");
   AST_SRC_MAP: assert property (##1 INTC_SRC == ((32'(ARRAY_IRQ1) << 24) | (32'(ARRAY_IRQ0) << 21))) // R10
      else $error("source bits misplaced");
   AST_STICKY: assert property (evt_q[0] && !(acc_wr && PADDR == 32'hFFFF0B58 && PWDATA[0]) |=> evt_q[0])
      else $error("event bit dropped without a clear");

   COV_LOCK: cover property (lock_q && acc_wr && PADDR == 32'hFFFF0B44);
   COV_IRQ_RISE: cover property (!ARRAY_IRQ0 ##1 ARRAY_IRQ0);
   COV_SET_CLEAR: cover property (evt_set[0] && acc_wr && PADDR == 32'hFFFF0B58 && PWDATA[0]);
endmodule : lar_routing_lock

/* testbench/lar_far_model.sv */
`timescale 1ns/1ps
// downstream view: interrupt source bits and converter start counter
module lar_far_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [31:0] intc_src,
   input wire logic adc_trig,
   output logic [1:0] irq_seen,
   output logic [7:0] start_cnt_q
);
   logic trig_q;
   assign irq_seen = {intc_src[24], intc_src[21]};
   // a conversion starts on each rising trigger; a level held high starts only one
   always_ff @(posedge clk) begin
      if (rst) begin
         trig_q <= 1'b0;
         start_cnt_q <= 8'h00;
      end else begin
         trig_q <= adc_trig;
         if (adc_trig && !trig_q) begin
            start_cnt_q <= start_cnt_q + 8'h01;
         end
      end
   end
endmodule : lar_far_model

/* testbench/lar_routing_lock_tb.sv */
`timescale 1ns/1ps
`include "lar_params.svh"
// self-checking bench for the routing and lock tail
module lar_routing_lock_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] elem_out = 16'h0;
   logic [175:0] elem_ctrl = 176'h0;
   logic [31:0] prdata, intc_src, rd_data;
   logic pready, pslverr, irq0, irq1, adc_trig, cfg_locked, evt_irq, bus_err;
   logic [15:0] elem_in, elem_fb1, pat;
   logic [1:0] irq_seen;
   logic [7:0] starts;
   int n_mismatch = 0;
   int check_count = 0;
   int cycles = 0;

`define CHK(got, exp) begin \
   check_count++; \
   if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("ERROR at %0t: got %0h expected %0h", $time, (got), (exp)); \
   end \
end

   lar_routing_lock lar_routing_lock_inst (.REF_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .ELEM_OUT(elem_out), .ELEM_CTRL(elem_ctrl), .ELEM_IN(elem_in), .ELEM_FB1(elem_fb1), .ARRAY_IRQ0(irq0),
      .ARRAY_IRQ1(irq1), .ADC_TRIG(adc_trig), .INTC_SRC(intc_src), .CFG_LOCKED(cfg_locked), .EVT_IRQ(evt_irq));
   lar_far_model lar_far_model_inst (.clk(clk), .rst(rst), .intc_src(intc_src), .adc_trig(adc_trig),
      .irq_seen(irq_seen), .start_cnt_q(starts));

   always #50 clk = ~clk;
   // a hang counts as a mismatch
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   // ----------------------------------------
   // bus and stimulus tasks
   // ----------------------------------------
   // request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd_data = prdata;
      bus_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // written value lands at the access edge; look just after it
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      #1;
   endtask : wr
   task automatic rchk(input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd_data, e)
   endtask : rchk
   // routed outputs carry one register stage
   task automatic drive_out(input logic [15:0] v);
      @(posedge clk);
      elem_out <= v;
      @(posedge clk);
      #1;
   endtask : drive_out
   task automatic do_reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset
   function automatic int src0(int e, int c);
      if (c != 0) return (e < 8) ? 2 * c : 8 + 2 * c;
      if (e == 0) return 15;
      if (e == 8) return 7;
      return (e < 8) ? 0 : 8;
   endfunction : src0
   task automatic end_of_test;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      do_reset();
      rchk(`LAR_ADDR_IRQ_ROUTE, 32'h0);
      rchk(`LAR_ADDR_CONV_TRIG, 32'h0);
      rchk(`LAR_ADDR_EVT_MASK, 32'h0);
      wr(`LAR_ADDR_SW_INPUTS, 32'hFFFF5AC3);
      rchk(`LAR_ADDR_SW_INPUTS, 32'h00005AC3);
      `CHK(elem_in, 16'h5AC3)
      drive_out(16'hA5C3);
      rchk(`LAR_ADDR_ELEM_OUTS, 32'h0000A5C3);
      for (int i = 0; i < 16; i++) begin
         wr(`LAR_ADDR_IRQ_ROUTE, {19'h0, 1'b1, 4'(15 - i), 3'h0, 1'b1, 4'(i)});
         drive_out(16'h1 << i);
         `CHK({irq1, irq0}, 2'b01)
         `CHK(intc_src, 32'h00200000)
         `CHK(irq_seen, 2'b01)
         drive_out(16'h8000 >> i);
         `CHK({irq1, irq0}, 2'b10)
         `CHK(intc_src, 32'h01000000)
         `CHK(irq_seen, 2'b10)
      end
      wr(`LAR_ADDR_IRQ_ROUTE, 32'h00000A05);
      drive_out(16'hFFFF);
      `CHK({irq1, irq0}, 2'b00)
      rchk(`LAR_ADDR_IRQ_ROUTE, 32'h00000A05);
      drive_out(16'h0);
      for (int i = 0; i < 16; i++) begin
         wr(`LAR_ADDR_CONV_TRIG, {27'h0, 1'b1, 4'(i)});
         drive_out(16'h1 << i);
         `CHK(adc_trig, 1'b1)
         drive_out(~(16'h1 << i));
         `CHK(adc_trig, 1'b0)
      end
      wr(`LAR_ADDR_CONV_TRIG, 32'h3);
      drive_out(16'hFFFF);
      `CHK(adc_trig, 1'b0)
      `CHK(starts, 8'h10)
      // feedback maps, a pattern and its inverse
      for (int c = 0; c < 4; c++) begin
         for (int k = 0; k < 2; k++) begin
            pat = (k == 0) ? 16'h6A39 : 16'h95C6;
            @(posedge clk);
            elem_ctrl <= {16{2'(c), 2'(c), 1'b1, 6'h0}};
            drive_out(pat);
            for (int e = 0; e < 16; e++) begin
               `CHK(elem_in[e], pat[src0(e, c)])
               `CHK(elem_fb1[e], pat[((e < 8) ? 1 : 9) + 2 * c])
            end
         end
      end
      // event status, mask and interrupt line
      drive_out(16'h0);
      wr(`LAR_ADDR_IRQ_ROUTE, 32'h00000010);
      wr(`LAR_ADDR_EVT_STATUS, 32'hF);
      drive_out(16'h0001);
      rchk(`LAR_ADDR_EVT_STATUS, 32'h1);
      `CHK(evt_irq, 1'b0)
      wr(`LAR_ADDR_EVT_MASK, 32'h1);
      #1;
      `CHK(evt_irq, 1'b1)
      wr(`LAR_ADDR_EVT_STATUS, 32'h1);
      #1;
      `CHK(evt_irq, 1'b0)
      // unmapped and read-only places
      apb(1'b0, 32'hFFFF0B60, 32'h0);
      `CHK({bus_err, rd_data}, {1'b1, 32'h0})
      apb(1'b1, `LAR_ADDR_ELEM_OUTS, 32'hFFFF);
      `CHK(bus_err, 1'b0)
      // first lock write consumed even when zero
      do_reset();
      rchk(`LAR_ADDR_CFG_LOCK, 32'h0);
      wr(`LAR_ADDR_CFG_LOCK, 32'h0);
      wr(`LAR_ADDR_CFG_LOCK, 32'h1);
      `CHK(cfg_locked, 1'b0)
      // locked writes ignored except software inputs
      do_reset();
      wr(`LAR_ADDR_CFG_LOCK, 32'h1);
      `CHK(cfg_locked, 1'b1)
      wr(`LAR_ADDR_IRQ_ROUTE, 32'h1F1F);
      wr(`LAR_ADDR_CONV_TRIG, 32'h1F);
      rchk(`LAR_ADDR_IRQ_ROUTE, 32'h0);
      rchk(`LAR_ADDR_CONV_TRIG, 32'h0);
      rchk(`LAR_ADDR_EVT_STATUS, 32'h8);
      wr(`LAR_ADDR_SW_INPUTS, 32'h1234);
      rchk(`LAR_ADDR_SW_INPUTS, 32'h1234);
      wr(`LAR_ADDR_CFG_LOCK, 32'h0);
      `CHK(cfg_locked, 1'b1)
      end_of_test();
   end
endmodule : lar_routing_lock_tb
